// ==== lpc_led_ctrl.sv ====
/*
  Keypad LED and backlight sink control: register file, 20 kHz
  internal keypad PWM, external PWM gating and backlight fading.
  Assumes a byte-wide register port already decoded from the host
  serial interface, and an external PWM pin that is asynchronous.
*/
`timescale 1ns/1ps
`include "lpc_params.svh"

module lpc_led_ctrl #(
  parameter int FADE_SLOW_CYC = `LPC_FADE_SLOW_CYC,
  // Fast slope is half the slow one; derived so one override moves both
  parameter int FADE_FAST_CYC = FADE_SLOW_CYC / 2,
  parameter int KPD_PWM_CYC   = `LPC_KPD_PWM_CYC,
  // Internal duty tracks the period, so shortening the period keeps 50 %
  parameter int KPD_PWM_HIGH  = KPD_PWM_CYC / 2
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_b,
  // Register write port
  input  wire logic          reg_wr_en,
  input  wire logic [7:0]    reg_wr_addr,
  input  wire logic [7:0]    reg_wr_data,
  // Register read port
  input  wire logic [7:0]    reg_rd_addr,
  output logic [7:0]         reg_rd_data,
  // External PWM pin, asynchronous
  input  wire logic          ext_pwm_pin,
  // Keypad sink controls
  output logic               kpd_out_a,
  output logic               kpd_out_b,
  output logic               kpd_out_c,
  output logic               kpd_output_mode,
  output logic [1:0]         kpd_a_current_scale,
  output logic [1:0]         kpd_b_current_scale,
  output logic [1:0]         kpd_c_current_scale,
  // Backlight sink controls
  output logic [7:0]         main_code,
  output logic [7:0]         sub_code,
  output logic               main_drive,
  output logic               sub_drive
);

  // Register state
  lpc_pkg::lpc_byte_t kpd_ctrl_ff,  nxt_kpd_ctrl;   // Keypad control
  lpc_pkg::lpc_byte_t kpd_scale_ff, nxt_kpd_scale;  // Keypad current scale
  lpc_pkg::lpc_byte_t wled_ctrl_ff, nxt_wled_ctrl;  // Backlight control
  lpc_pkg::lpc_byte_t main_tgt_ff,  nxt_main_tgt;   // Main target code
  lpc_pkg::lpc_byte_t sub_tgt_ff,   nxt_sub_tgt;    // Sub target code
  lpc_pkg::lpc_byte_t gpio_ctrl_ff, nxt_gpio_ctrl;  // GPIO control
  lpc_pkg::lpc_byte_t kpd_gate_ff,  nxt_kpd_gate;   // Keypad gate selects
  lpc_pkg::lpc_byte_t wled_pwm_ff,  nxt_wled_pwm;   // Backlight PWM enables
  lpc_pkg::lpc_byte_t rd_data_ff,   nxt_rd_data;    // Read data

  // Pin synchroniser
  logic pwm_meta_ff;   // First stage, read only by second
  logic pwm_sync_ff;   // Safe to use

  // Timing and fade state
  logic [11:0] pwm_cnt_ff,  nxt_pwm_cnt;    // Internal PWM phase
  logic [23:0] fade_cnt_ff, nxt_fade_cnt;   // Fade step prescaler
  lpc_pkg::lpc_byte_t main_cur_ff, nxt_main_cur;  // Main live code
  lpc_pkg::lpc_byte_t sub_cur_ff,  nxt_sub_cur;   // Sub live code

  // Output flops
  logic [2:0] kpd_out_ff, nxt_kpd_out;
  logic       mode_ff, nxt_mode;
  logic [5:0] scale_ff, nxt_scale;
  lpc_pkg::lpc_byte_t main_code_ff, nxt_main_code;
  lpc_pkg::lpc_byte_t sub_code_ff,  nxt_sub_code;
  logic       main_drive_ff, nxt_main_drive;
  logic       sub_drive_ff,  nxt_sub_drive;

  // Decoded controls
  logic       blk_en, int_sel, pin_en, int_pwm, fade_en, fade_sel, shared;
  logic [2:0] on_bits, gate_bits;
  logic [23:0] step_lim;
  logic        fade_tick;

  assign blk_en    = kpd_ctrl_ff[`LPC_KC_BLOCK_EN];
  assign int_sel   = kpd_ctrl_ff[`LPC_KC_INT_PWM];
  assign on_bits   = kpd_ctrl_ff[2:0];
  assign gate_bits = kpd_gate_ff[2:0];
  assign pin_en    = gpio_ctrl_ff[`LPC_GC_PWM_PIN];
  assign fade_en   = wled_ctrl_ff[`LPC_WC_FADE_EN];
  assign fade_sel  = wled_ctrl_ff[`LPC_WC_FADE_SEL];
  assign shared    = wled_ctrl_ff[`LPC_WC_SHARED];
  assign int_pwm   = (pwm_cnt_ff < 12'(KPD_PWM_HIGH));
  // Slope bit picks the per-step interval
  assign step_lim  = wled_ctrl_ff[`LPC_WC_SLOPE] ? 24'(FADE_FAST_CYC - 1)
                                                 : 24'(FADE_SLOW_CYC - 1);
  assign fade_tick = (fade_cnt_ff >= step_lim);

  // Register writes; unmapped addresses are dropped
  always_comb begin
    nxt_kpd_ctrl  = kpd_ctrl_ff;
    nxt_kpd_scale = kpd_scale_ff;
    nxt_wled_ctrl = wled_ctrl_ff;
    nxt_main_tgt  = main_tgt_ff;
    nxt_sub_tgt   = sub_tgt_ff;
    nxt_gpio_ctrl = gpio_ctrl_ff;
    nxt_kpd_gate  = kpd_gate_ff;
    nxt_wled_pwm  = wled_pwm_ff;
    if (reg_wr_en) begin
      case (reg_wr_addr)
        `LPC_ADDR_KPD_CTRL:  nxt_kpd_ctrl  = {2'h0, reg_wr_data[5:0]};
        `LPC_ADDR_KPD_SCALE: nxt_kpd_scale = {2'h0, reg_wr_data[5:0]};
        `LPC_ADDR_WLED_CTRL: nxt_wled_ctrl = {2'h0, reg_wr_data[5:0]};
        `LPC_ADDR_MAIN_CODE: nxt_main_tgt  = reg_wr_data;
        `LPC_ADDR_SUB_CODE:  nxt_sub_tgt   = reg_wr_data;
        `LPC_ADDR_GPIO_CTRL: nxt_gpio_ctrl = {3'h0, reg_wr_data[4], 4'h0};
        `LPC_ADDR_KPD_GATE:  nxt_kpd_gate  = {5'h0, reg_wr_data[2:0]};
        `LPC_ADDR_WLED_PWM:  nxt_wled_pwm  = {6'h0, reg_wr_data[1:0]};
        default: ;
      endcase
    end
  end

  // Register storage; switch mode after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kpd_ctrl_ff  <= `LPC_RST_KPD_CTRL;
      kpd_scale_ff <= `LPC_RST_ZERO;
      wled_ctrl_ff <= `LPC_RST_ZERO;
      main_tgt_ff  <= `LPC_RST_ZERO;
      sub_tgt_ff   <= `LPC_RST_ZERO;
      gpio_ctrl_ff <= `LPC_RST_ZERO;
      kpd_gate_ff  <= `LPC_RST_ZERO;
      wled_pwm_ff  <= `LPC_RST_ZERO;
    end else begin
      kpd_ctrl_ff  <= nxt_kpd_ctrl;
      kpd_scale_ff <= nxt_kpd_scale;
      wled_ctrl_ff <= nxt_wled_ctrl;
      main_tgt_ff  <= nxt_main_tgt;
      sub_tgt_ff   <= nxt_sub_tgt;
      gpio_ctrl_ff <= nxt_gpio_ctrl;
      kpd_gate_ff  <= nxt_kpd_gate;
      wled_pwm_ff  <= nxt_wled_pwm;
    end
  end

  // Read mux, one cycle latency; unmapped reads give zero
  always_comb begin
    case (reg_rd_addr)
      `LPC_ADDR_KPD_CTRL:  nxt_rd_data = kpd_ctrl_ff;
      `LPC_ADDR_KPD_SCALE: nxt_rd_data = kpd_scale_ff;
      `LPC_ADDR_WLED_CTRL: nxt_rd_data = wled_ctrl_ff;
      `LPC_ADDR_MAIN_CODE: nxt_rd_data = main_tgt_ff;
      `LPC_ADDR_SUB_CODE:  nxt_rd_data = sub_tgt_ff;
      `LPC_ADDR_GPIO_CTRL: nxt_rd_data = gpio_ctrl_ff;
      `LPC_ADDR_KPD_GATE:  nxt_rd_data = kpd_gate_ff;
      `LPC_ADDR_WLED_PWM:  nxt_rd_data = wled_pwm_ff;
      default:             nxt_rd_data = `LPC_RST_ZERO;
    endcase
  end

  // Read data register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= `LPC_RST_ZERO;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Two-stage synchroniser on the PWM pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_meta_ff <= 1'b0;
      pwm_sync_ff <= 1'b0;
    end else begin
      pwm_meta_ff <= ext_pwm_pin;
      pwm_sync_ff <= pwm_meta_ff;
    end
  end

  // Internal keypad PWM phase, free running
  always_comb begin
    if (pwm_cnt_ff >= 12'(KPD_PWM_CYC - 1)) begin
      nxt_pwm_cnt = 12'h000;
    end else begin
      nxt_pwm_cnt = pwm_cnt_ff + 12'h001;
    end
  end

  // Internal PWM register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt_ff <= 12'h000;
    end else begin
      pwm_cnt_ff <= nxt_pwm_cnt;
    end
  end

  // Fade: live codes walk one step per tick, so time scales with change
  always_comb begin
    nxt_fade_cnt = fade_tick ? 24'h000000 : fade_cnt_ff + 24'h000001;
    nxt_main_cur = main_tgt_ff;
    nxt_sub_cur  = sub_tgt_ff;
    if (fade_en && !fade_sel) begin
      // Main fades; with shared DAC sub follows main
      nxt_main_cur = main_cur_ff;
      if (fade_tick && main_cur_ff < main_tgt_ff) begin
        nxt_main_cur = main_cur_ff + 8'h01;
      end else if (fade_tick && main_cur_ff > main_tgt_ff) begin
        nxt_main_cur = main_cur_ff - 8'h01;
      end
    end else if (fade_en && fade_sel) begin
      // Sub fades alone
      nxt_sub_cur = sub_cur_ff;
      if (fade_tick && sub_cur_ff < sub_tgt_ff) begin
        nxt_sub_cur = sub_cur_ff + 8'h01;
      end else if (fade_tick && sub_cur_ff > sub_tgt_ff) begin
        nxt_sub_cur = sub_cur_ff - 8'h01;
      end
    end
  end

  // Fade registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fade_cnt_ff <= 24'h000000;
      main_cur_ff <= `LPC_RST_ZERO;
      sub_cur_ff  <= `LPC_RST_ZERO;
    end else begin
      fade_cnt_ff <= nxt_fade_cnt;
      main_cur_ff <= nxt_main_cur;
      sub_cur_ff  <= nxt_sub_cur;
    end
  end

  // Output decisions; brightness register plays no part here
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!blk_en || !on_bits[i]) begin
        nxt_kpd_out[i] = 1'b0;
      end else if (gate_bits[i] && pin_en) begin
        // Active high gate, AND with internal PWM when selected
        nxt_kpd_out[i] = int_sel ? (pwm_sync_ff & int_pwm) : pwm_sync_ff;
      end else begin
        nxt_kpd_out[i] = int_sel ? int_pwm : 1'b1;
      end
    end
    nxt_mode  = kpd_ctrl_ff[`LPC_KC_MODE];
    nxt_scale = kpd_scale_ff[5:0];
    nxt_main_code = main_cur_ff;
    nxt_sub_code  = shared ? main_cur_ff : sub_cur_ff;
    nxt_main_drive = wled_ctrl_ff[`LPC_WC_MAIN_EN] &
                     (!(wled_pwm_ff[`LPC_WP_MAIN] && pin_en) | pwm_sync_ff);
    nxt_sub_drive  = wled_ctrl_ff[`LPC_WC_SUB_EN] &
                     (!(wled_pwm_ff[`LPC_WP_SUB] && pin_en) | pwm_sync_ff);
  end

  // Output registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      kpd_out_ff    <= 3'h0;
      mode_ff       <= 1'b1;
      scale_ff      <= 6'h00;
      main_code_ff  <= `LPC_RST_ZERO;
      sub_code_ff   <= `LPC_RST_ZERO;
      main_drive_ff <= 1'b0;
      sub_drive_ff  <= 1'b0;
    end else begin
      kpd_out_ff    <= nxt_kpd_out;
      mode_ff       <= nxt_mode;
      scale_ff      <= nxt_scale;
      main_code_ff  <= nxt_main_code;
      sub_code_ff   <= nxt_sub_code;
      main_drive_ff <= nxt_main_drive;
      sub_drive_ff  <= nxt_sub_drive;
    end
  end

  // Port drive, all from flops
  assign reg_rd_data         = rd_data_ff;
  assign kpd_out_a           = kpd_out_ff[0];
  assign kpd_out_b           = kpd_out_ff[1];
  assign kpd_out_c           = kpd_out_ff[2];
  assign kpd_output_mode     = mode_ff;
  assign kpd_a_current_scale = scale_ff[5:4];
  assign kpd_b_current_scale = scale_ff[3:2];
  assign kpd_c_current_scale = scale_ff[1:0];
  assign main_code           = main_code_ff;
  assign sub_code            = sub_code_ff;
  assign main_drive          = main_drive_ff;
  assign sub_drive           = sub_drive_ff;

  // Checks
  property p_blk_off;
    @(posedge mclk) disable iff (!rst_b) !blk_en |=> (kpd_out_ff == 3'h0);
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("keypad on while block disabled");

  property p_direct_on;
    @(posedge mclk) disable iff (!rst_b)
      (blk_en && !int_sel && on_bits[0] && !(gate_bits[0] && pin_en)) |=> kpd_out_a;
  endproperty
  a_direct_on: assert property (p_direct_on) else $error("direct mode output not on");

  property p_ext_direct;
    @(posedge mclk) disable iff (!rst_b)
      (blk_en && !int_sel && on_bits[1] && gate_bits[1] && pin_en) |=> (kpd_out_b == $past(pwm_sync_ff));
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("gated output not following pin");

  property p_ext_and;
    @(posedge mclk) disable iff (!rst_b)
      (int_sel && gate_bits[2] && pin_en && !pwm_sync_ff) |=> !kpd_out_c;
  endproperty
  a_ext_and: assert property (p_ext_and) else $error("gated output on while pin low");

  property p_pwm_wrap;
    @(posedge mclk) disable iff (!rst_b)
      (pwm_cnt_ff == 12'(KPD_PWM_CYC - 1)) |=> (pwm_cnt_ff == 12'h000);
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("internal PWM period wrong");

  property p_scale_map;
    @(posedge mclk) disable iff (!rst_b)
      (reg_wr_en && reg_wr_addr == `LPC_ADDR_KPD_SCALE) |=> ##1
        (kpd_a_current_scale == $past(reg_wr_data[5:4], 2) && kpd_c_current_scale == $past(reg_wr_data[1:0], 2));
  endproperty
  a_scale_map: assert property (p_scale_map) else $error("scale fields misplaced");

  property p_shared;
    @(posedge mclk) disable iff (!rst_b) shared |=> (sub_code_ff == main_code_ff);
  endproperty
  a_shared: assert property (p_shared) else $error("shared DAC codes differ");

  property p_bl_gate;
    @(posedge mclk) disable iff (!rst_b)
      (wled_pwm_ff[`LPC_WP_MAIN] && pin_en && !pwm_sync_ff) |=> !main_drive;
  endproperty
  a_bl_gate: assert property (p_bl_gate) else $error("main sink on while pin low");

  property p_no_fade;
    @(posedge mclk) disable iff (!rst_b) !fade_en |=> (main_cur_ff == $past(main_tgt_ff));
  endproperty
  a_no_fade: assert property (p_no_fade) else $error("code moved without fade");

  property p_fade_step;
    @(posedge mclk) disable iff (!rst_b)
      (fade_en && !fade_sel && !fade_tick) |=> $stable(main_cur_ff);
  endproperty
  a_fade_step: assert property (p_fade_step) else $error("fade stepped off tick");

endmodule // lpc_led_ctrl

// ==== lpc_params.svh ====
/*
  Constants for the keypad and backlight LED control block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 50 MHz core clock and an 8-bit register port fed by the
  host serial interface decoder.
*/
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

// Register offsets
`define LPC_ADDR_KPD_CTRL   8'h00
`define LPC_ADDR_KPD_SCALE  8'h02
`define LPC_ADDR_WLED_CTRL  8'h03
`define LPC_ADDR_MAIN_CODE  8'h04
`define LPC_ADDR_SUB_CODE   8'h05
`define LPC_ADDR_GPIO_CTRL  8'h06
`define LPC_ADDR_KPD_GATE   8'h08
`define LPC_ADDR_WLED_PWM   8'h2b

// Keypad control fields
`define LPC_KC_A_ON         0
`define LPC_KC_B_ON         1
`define LPC_KC_C_ON         2
`define LPC_KC_BLOCK_EN     3
`define LPC_KC_INT_PWM      4
`define LPC_KC_MODE         5

// Keypad current scale fields (low bit of each pair)
`define LPC_KS_A_LSB        4
`define LPC_KS_B_LSB        2
`define LPC_KS_C_LSB        0

// Backlight control fields
`define LPC_WC_SUB_EN       0
`define LPC_WC_MAIN_EN      1
`define LPC_WC_SHARED       2
`define LPC_WC_FADE_EN      3
`define LPC_WC_FADE_SEL     4
`define LPC_WC_SLOPE        5

// Other fields
`define LPC_GC_PWM_PIN      4
`define LPC_WP_SUB          0
`define LPC_WP_MAIN         1

// Reset values
`define LPC_RST_KPD_CTRL    8'h20
`define LPC_RST_ZERO        8'h00

// Timing
`define LPC_CLK_KHZ         50000
`define LPC_KPD_PWM_KHZ     20
`define LPC_KPD_PWM_CYC     (`LPC_CLK_KHZ / `LPC_KPD_PWM_KHZ)
`define LPC_FADE_SLOW_MS    1300
`define LPC_FADE_FAST_MS    650
`define LPC_FADE_STEPS      255
`define LPC_FADE_SLOW_CYC   ((`LPC_FADE_SLOW_MS * `LPC_CLK_KHZ) / `LPC_FADE_STEPS)
`define LPC_FADE_FAST_CYC   ((`LPC_FADE_FAST_MS * `LPC_CLK_KHZ) / `LPC_FADE_STEPS)

`endif

// ==== lpc_pkg.sv ====
/*
  Types shared by the LED control block.
  Assumes lpc_params.svh supplies all numeric constants.
*/
package lpc_pkg;
  // One register byte
  typedef logic [7:0] lpc_byte_t;
  // Two-bit current scale code
  typedef logic [1:0] lpc_scale_t;
endpackage

// ==== lpc_pwm_src.sv ====
/*
  Behavioural external PWM source that drives the shared pin zero.
  Assumes the bench calls set_level a little after a clock edge.
*/
`timescale 1ns/1ps
module lpc_pwm_src (
  // Pin toward the device
  output logic ext_pwm_pin
);
  logic lvl_q = 1'b0;  // Level asked for by the bench

  // Pin follows the request at once; the device must synchronise it
  assign ext_pwm_pin = lvl_q;

  // Set a new pin level, high means the LEDs may light
  task automatic set_level(input logic lvl);
    lvl_q = lvl;
  endtask
endmodule // lpc_pwm_src

// ==== lpc_led_ctrl_test.sv ====
/*
  Self-checking bench for the keypad and backlight LED control block.
  Assumes lpc_params.svh and lpc_pkg, and a partner lpc_pwm_src on the pin.
*/
`timescale 1ns/1ps
`include "lpc_params.svh"
module lpc_led_ctrl_test;
  localparam int SLOW = 8;   // Shortened fade step, slope zero
  localparam int FAST = SLOW / 2;  // Fade step, slope one, half of slope zero
  localparam int PER  = 10;  // Shortened internal PWM period
  localparam lpc_pkg::lpc_byte_t KC = `LPC_ADDR_KPD_CTRL;
  localparam lpc_pkg::lpc_byte_t KS = `LPC_ADDR_KPD_SCALE;
  localparam lpc_pkg::lpc_byte_t KG = `LPC_ADDR_KPD_GATE;
  localparam lpc_pkg::lpc_byte_t GC = `LPC_ADDR_GPIO_CTRL;
  localparam lpc_pkg::lpc_byte_t WC = `LPC_ADDR_WLED_CTRL;
  localparam lpc_pkg::lpc_byte_t WP = `LPC_ADDR_WLED_PWM;
  localparam lpc_pkg::lpc_byte_t MC = `LPC_ADDR_MAIN_CODE;
  localparam lpc_pkg::lpc_byte_t SC = `LPC_ADDR_SUB_CODE;
  // Design side signals
  logic       mclk, rst_b, reg_wr_en, ext_pwm_pin;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  logic       kpd_out_a, kpd_out_b, kpd_out_c, kpd_output_mode;
  logic [1:0] kpd_a_current_scale, kpd_b_current_scale, kpd_c_current_scale;
  logic [7:0] main_code, sub_code;
  logic       main_drive, sub_drive;
  int         bad_count, cmp_count;  // Mismatch and compare tallies
  int         n, ha, hb;             // Cycle and high counts

  // Device under test, counts shortened to keep the run brief
  lpc_led_ctrl #(.FADE_SLOW_CYC(SLOW), .KPD_PWM_CYC(PER)) u_lpc_led_ctrl (
    .mclk(mclk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .ext_pwm_pin(ext_pwm_pin), .kpd_out_a(kpd_out_a), .kpd_out_b(kpd_out_b),
    .kpd_out_c(kpd_out_c), .kpd_output_mode(kpd_output_mode),
    .kpd_a_current_scale(kpd_a_current_scale), .kpd_b_current_scale(kpd_b_current_scale),
    .kpd_c_current_scale(kpd_c_current_scale), .main_code(main_code), .sub_code(sub_code),
    .main_drive(main_drive), .sub_drive(sub_drive));
  // Far side PWM source
  lpc_pwm_src u_lpc_pwm_src (.ext_pwm_pin(ext_pwm_pin));

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Wait k edges, then land 1 ns past the last one
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // One-cycle register write strobe
  task automatic wr(input lpc_pkg::lpc_byte_t a, input lpc_pkg::lpc_byte_t d);
    cyc(1);
    reg_wr_en   = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    cyc(1);
    reg_wr_en   = 1'b0;
  endtask

  // Compare and tally
  task automatic chk(input lpc_pkg::lpc_byte_t seen, input lpc_pkg::lpc_byte_t exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Read data lags the address by one edge, so allow two
  task automatic chk_rd(input lpc_pkg::lpc_byte_t a, input lpc_pkg::lpc_byte_t exp);
    reg_rd_addr = a;
    cyc(2);
    chk(reg_rd_data, exp);
  endtask

  // Count cycles with outputs a and b high
  task automatic count_hi(input int k);
    ha = 0;
    hb = 0;
    repeat (k) begin
      cyc(1);
      ha += int'(kpd_out_a);
      hb += int'(kpd_out_b);
    end
  endtask

  // Cycles until a live code reaches its target, bounded
  task automatic ramp(input logic sub, input lpc_pkg::lpc_byte_t tgt);
    n = 0;
    while ((sub ? sub_code : main_code) !== tgt && n < 400) begin
      cyc(1);
      n++;
    end
  endtask

  // Ramp time fits the step count; step timer phase is free
  function automatic logic in_win(input int steps, input int step);
    return n >= (steps - 1) * step && n <= steps * step + 3;
  endfunction

  // Reset values and an unmapped read
  task automatic t_reset;
    chk(kpd_output_mode, 8'h01);
    chk({kpd_out_a, kpd_out_b, kpd_out_c, main_drive, sub_drive}, 8'h00);
    chk_rd(KC, `LPC_RST_KPD_CTRL);
    chk_rd(KS, 8'h00);
    chk_rd(8'h01, 8'h00);
    $display("reset test done");
  endtask

  // Direct on/off, mode bit, block disable
  task automatic t_direct;
    wr(KC, 8'h2d);
    wr(8'h01, 8'h02);  // Dim brightness must not take effect
    cyc(2);
    chk({kpd_out_a, kpd_out_b, kpd_out_c}, 8'h05);
    count_hi(20);
    chk(ha[7:0], 8'h14);
    wr(KC, 8'h0e);
    cyc(2);
    chk({kpd_out_a, kpd_out_b, kpd_out_c, kpd_output_mode}, 8'h06);
    wr(KC, 8'h27);  // Block off, all three asked on
    cyc(2);
    chk({kpd_out_a, kpd_out_b, kpd_out_c}, 8'h00);
    $display("direct test done");
  endtask

  // Every scale code on every output, then mixed fields
  task automatic t_scale;
    for (int c = 0; c < 4; c++) begin
      wr(KS, {2'b00, c[1:0], c[1:0], c[1:0]});
      cyc(2);
      chk({kpd_a_current_scale, kpd_b_current_scale, kpd_c_current_scale}, {2'b00, c[1:0], c[1:0], c[1:0]});
    end
    wr(KS, 8'hdb);
    cyc(2);
    chk({kpd_a_current_scale, kpd_b_current_scale, kpd_c_current_scale}, 8'h1b);
    chk_rd(KS, 8'h1b);
    $display("scale test done");
  endtask

  // External gating with internal PWM off
  task automatic t_ext;
    wr(KC, 8'h0f);
    wr(KG, 8'h01);
    wr(GC, 8'h10);
    chk_rd(GC, 8'h10);
    u_lpc_pwm_src.set_level(1'b0);
    cyc(4);
    chk({kpd_out_a, kpd_out_b, kpd_out_c}, 8'h03);
    u_lpc_pwm_src.set_level(1'b1);
    cyc(4);
    chk({kpd_out_a, kpd_out_b, kpd_out_c}, 8'h07);
    wr(KG, 8'h06);
    u_lpc_pwm_src.set_level(1'b0);
    cyc(4);
    chk({kpd_out_a, kpd_out_b, kpd_out_c}, 8'h04);
    $display("external gating test done");
  endtask

  // Internal PWM masked by the pin on outputs a and c, b ungated
  task automatic t_int;
    wr(KC, 8'h1f);
    wr(KG, 8'h05);  // Gate a and c, so the AND path on c is exercised too
    u_lpc_pwm_src.set_level(1'b1);
    cyc(4);
    count_hi(10 * PER);
    chk(ha[7:0], 8'h32);
    chk(hb[7:0], 8'h32);
    u_lpc_pwm_src.set_level(1'b0);
    cyc(4);
    count_hi(10 * PER);
    chk(ha[7:0], 8'h00);
    chk(hb[7:0], 8'h32);
    $display("internal PWM test done");
  endtask

  // Backlight codes, shared DAC and pin gating
  task automatic t_wled;
    wr(MC, 8'h80);
    wr(SC, 8'h3c);
    wr(WC, 8'h03);
    cyc(2);
    chk(main_code, 8'h80);
    chk(sub_code, 8'h3c);
    wr(WC, 8'h07);
    cyc(2);
    chk(sub_code, 8'h80);
    wr(WP, 8'h02);
    cyc(4);
    chk({main_drive, sub_drive}, 8'h01);
    u_lpc_pwm_src.set_level(1'b1);
    cyc(4);
    chk({main_drive, sub_drive}, 8'h03);
    u_lpc_pwm_src.set_level(1'b0);
    wr(GC, 8'h00);  // Pin function off, so no gating
    cyc(4);
    chk({main_drive, sub_drive}, 8'h03);
    $display("backlight test done");
  endtask

  // Fading: rates, partial changes, channel select, shared DAC
  task automatic t_fade;
    wr(WP, 8'h00);
    wr(WC, 8'h03);
    wr(MC, 8'h00);
    ramp(1'b0, 8'h00);
    chk(n <= 2, 8'h01);
    wr(SC, 8'h00);
    wr(WC, 8'h0b);
    wr(MC, 8'h05);
    ramp(1'b0, 8'h05);
    chk(in_win(5, SLOW), 8'h01);
    wr(WC, 8'h2b);
    wr(MC, 8'h0d);
    ramp(1'b0, 8'h0d);
    chk(in_win(8, FAST), 8'h01);
    wr(WC, 8'h3b);
    wr(SC, 8'h04);
    ramp(1'b1, 8'h04);
    chk(in_win(4, FAST), 8'h01);
    wr(MC, 8'h20);
    ramp(1'b0, 8'h20);
    chk(n <= 2, 8'h01);
    wr(WC, 8'h0f);
    wr(MC, 8'h10);
    cyc(40);
    chk(sub_code, main_code);
    chk(main_code > 8'h10 && main_code < 8'h20, 8'h01);
    ramp(1'b0, 8'h10);
    n += 40;  // Ramp began before the 40-cycle wait above
    chk(in_win(16, SLOW), 8'h01);
    $display("fade test done");
  endtask

  // Counts, verdict and end of run
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    mclk        = 1'b0;
    rst_b       = 1'b0;
    reg_wr_en   = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
    bad_count   = 0;
    cmp_count   = 0;
    cyc(16);
    rst_b = 1'b1;
    t_reset;
    t_direct;
    t_scale;
    t_ext;
    t_int;
    t_wled;
    t_fade;
    summarize;
  end

  // Watchdog; the tests need well under 50 us
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize;
  end
endmodule // lpc_led_ctrl_test
